/* File: testbench/tb.sv */
// ----------------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------------
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("MISMATCH t=%0t got %h want %h", $time, a, e); \
      end \
   end

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [15:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic ext0_level_mode;
   logic [23:0] periph_irq = 24'h000000;
   logic [2:0] uart_irq_mask = 3'h7;
   logic [3:0] core_src = 4'h0;
   logic line;
   logic edge_trig;
   logic [4:0] req;
   logic [15:0] addr;
   logic [7:0] v;
   int failures = 0;
   int comparisons = 0;
   localparam via_pkg::via_vec_t VEC[22] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
      8'h30, 8'h32, 8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50,
      8'h52, 8'h60, 8'h62, 8'h80, 8'h84};
   localparam logic [15:0] CADDR[5] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023};

   always #5 sys_clk = ~sys_clk;

   via_core_model via_core_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .ext0_level_mode(ext0_level_mode));

   via_top via_top_i (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ext0_level_mode(ext0_level_mode), .periph_irq(periph_irq),
      .uart_irq_mask(uart_irq_mask), .timer_zero_irq(core_src[0]),
      .external_one_irq(core_src[1]), .timer_one_irq(core_src[2]),
      .serial_port_irq(core_src[3]), .combined_peripheral_irq_line(line),
      .ext0_edge_trig(edge_trig), .core_irq_req(req), .core_irq_addr(addr));

   task automatic pulse(input logic [23:0] bits);
      @(negedge sys_clk);
      periph_irq = bits;
      @(negedge sys_clk);
      periph_irq = 24'h000000;
      @(negedge sys_clk);
   endtask

   task automatic t_reset();
      via_core_model_i.rd(16'h00A8, v);
      `CHK(v, 8'h00)
      via_core_model_i.rd(16'hFF92, v);
      `CHK(v, 8'h00)
      `CHK(line, 1'b1)
      `CHK(edge_trig, 1'b1)
   endtask

   // global enable off must hide sources one to four even with their own bits set
   task automatic t_core();
      core_src = 4'hF;
      via_core_model_i.wr(16'h00A8, 8'h1E);
      @(negedge sys_clk);
      `CHK(req, 5'h00)
      for (int i = 1; i < 5; i++)
      begin
         via_core_model_i.wr(16'h00A8, 8'h80 | (8'h01 << i));
         @(negedge sys_clk);
         `CHK(req, 5'h01 << i)
         `CHK(addr, CADDR[i])
      end
      via_core_model_i.wr(16'h00A8, 8'hFF);
      via_core_model_i.wr(16'h00A9, 8'h00);
      via_core_model_i.rd(16'h00A8, v);
      `CHK(v, 8'h9F)
      via_core_model_i.rd(16'h1234, v);
      `CHK(v, 8'h00)
      // a write while the clock enable is low must not land
      @(negedge sys_clk);
      clk_en = 1'b0;
      via_core_model_i.wr(16'h00A8, 8'h00);
      clk_en = 1'b1;
      via_core_model_i.rd(16'h00A8, v);
      `CHK(v, 8'h9F)
      core_src = 4'h0;
   endtask

   task automatic t_vectors();
      via_core_model_i.set_level();
      via_core_model_i.wr(16'h00A8, 8'h81);
      `CHK(edge_trig, 1'b0)
      for (int i = 0; i < 22; i++)
      begin
         pulse(24'h000001 << i);
         `CHK(line, 1'b0)
         `CHK(addr, CADDR[0])
         via_core_model_i.service(v);
         `CHK(v, VEC[i])
         `CHK(v[0], 1'b0)
         @(negedge sys_clk);
         `CHK(line, 1'b1)
         via_core_model_i.rd(16'hFF92, v);
         `CHK(v, 8'h00)
      end
   endtask

   task automatic t_prio();
      pulse(24'h200001);
      via_core_model_i.service(v);
      `CHK(v, 8'h84)
      via_core_model_i.service(v);
      `CHK(v, 8'h12)
      pulse(24'h000002);
      pulse(24'h000001);
      via_core_model_i.service(v);
      `CHK(v, 8'h14)
      via_core_model_i.service(v);
      `CHK(v, 8'h12)
   endtask

   // kept last: a masked arrival might be held and would upset later reads
   task automatic t_mask();
      @(negedge sys_clk);
      uart_irq_mask = 3'h1;
      pulse(24'h0F0000);
      via_core_model_i.service(v);
      `CHK(v, 8'h52)
      via_core_model_i.rd(16'hFF92, v);
      `CHK(v, 8'h00)
      uart_irq_mask = 3'h0;
      pulse(24'h0F0000);
      @(negedge sys_clk);
      `CHK(line, 1'b1)
      via_core_model_i.rd(16'hFF92, v);
      `CHK(v, 8'h00)
   endtask

   task automatic print_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      failures++;
      print_verdict();
   end

   initial
   begin
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_core();
      t_vectors();
      t_prio();
      t_mask();
      print_verdict();
   end
endmodule

/* File: testbench/via_core_model.sv */
// ----------------------------------------------------------------------
// core and firmware side of the register port
// ----------------------------------------------------------------------
module via_core_model
(
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic ext0_level_mode
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      ext0_level_mode = 1'b0;
   end

   // one-cycle strobe; data inverted after so a stale byte is never reused
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   task automatic set_level();
      @(negedge sys_clk);
      ext0_level_mode = 1'b1;
   endtask

   // read the vector, then retire it with an arbitrary byte
   task automatic service(output logic [7:0] v);
      rd(16'hFF92, v);
      wr(16'hFF92, 8'hA5);
   endtask
endmodule

/* File: verilog/via_defines.svh */
`ifndef VIA_DEFINES_SVH
`define VIA_DEFINES_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define VIA_STD_IRQ_ENABLE_ADDR 16'h00A8
`define VIA_PENDING_VECTOR_ADDR 16'hFF92
`define VIA_STD_IRQ_ENABLE_RESET 8'h00
`define VIA_STD_IRQ_ENABLE_WMASK 8'h9F

// ----------------------------------------------------------------------
// enable bit positions
// ----------------------------------------------------------------------
`define VIA_EN_EXT0 0
`define VIA_EN_TMR0 1
`define VIA_EN_EXT1 2
`define VIA_EN_TMR1 3
`define VIA_EN_SER 4
`define VIA_EN_GLOBAL 7

// ----------------------------------------------------------------------
// core start addresses
// ----------------------------------------------------------------------
`define VIA_ADDR_RESET 16'h0000
`define VIA_ADDR_EXT0 16'h0003
`define VIA_ADDR_TMR0 16'h000B
`define VIA_ADDR_EXT1 16'h0013
`define VIA_ADDR_TMR1 16'h001B
`define VIA_ADDR_SER 16'h0023

// ----------------------------------------------------------------------
// vector codes
// ----------------------------------------------------------------------
`define VIA_VEC_NONE 8'h00
`define VIA_VEC_OEP1 8'h12
`define VIA_VEC_OEP2 8'h14
`define VIA_VEC_OEP3 8'h16
`define VIA_VEC_IEP1 8'h22
`define VIA_VEC_IEP2 8'h24
`define VIA_VEC_IEP3 8'h26
`define VIA_VEC_SETUP_OVWR 8'h30
`define VIA_VEC_SETUP 8'h32
`define VIA_VEC_RESUME 8'h38
`define VIA_VEC_SUSPEND 8'h3A
`define VIA_VEC_BUSRST 8'h3C
`define VIA_VEC_WAKEUP 8'h3E
`define VIA_VEC_TW_TX_EMPTY 8'h40
`define VIA_VEC_TW_RX_FULL 8'h42
`define VIA_VEC_IEP0 8'h44
`define VIA_VEC_OEP0 8'h46
`define VIA_VEC_U_STAT 8'h50
`define VIA_VEC_U_MODEM 8'h52
`define VIA_VEC_U_RX_FULL 8'h60
`define VIA_VEC_U_TX_EMPTY 8'h62
`define VIA_VEC_DMA_ONE 8'h80
`define VIA_VEC_DMA_THREE 8'h84

`endif

/* File: verilog/via_pkg.sv */
package via_pkg;
   typedef enum logic [1:0] {
      VIA_EDGE = 2'b01,
      VIA_LEVEL = 2'b10
   } via_trig_e;
   typedef logic [7:0] via_vec_t;
endpackage

/* File: verilog/via_top.sv */
// Operation
// - or peripheral requests zero to twenty-one onto external zero
// - external zero starts edge-triggered after reset
// - vector space covers sixteen groups of eight sources
// - priority encoder yields eight-bit vector code
// - any vector write retires current vector
// - vector bit zero always reads zero
// - vector reads zero when nothing pending
// - group bits seven-four, index three-one
// - within group, first come first served
// - higher group wins, group fifteen highest
// - usb endpoint sources at fixed vectors
// - usb bus events in group three
// - two-wire master at forty and forty-two
// - uart sources at fifty, fifty-two, sixty, sixty-two
// - dma one eighty, dma three eighty-four
// - core sources at fixed start addresses
// - enable register at a8, resets zero
// - global enable zero masks all five core requests
// - per-source enable gates each core source
// - uart sources gated by uart mask bits
`include "via_defines.svh"
module via_top
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic ext0_level_mode,
   input wire logic [23:0] periph_irq,
   input wire logic [2:0] uart_irq_mask,
   input wire logic timer_zero_irq,
   input wire logic external_one_irq,
   input wire logic timer_one_irq,
   input wire logic serial_port_irq,
   output logic combined_peripheral_irq_line,
   output logic ext0_edge_trig,
   output logic [4:0] core_irq_req,
   output logic [15:0] core_irq_addr
);

   // ----------------------------------------------------------------------
   // source table: periph_irq bit n maps to vec_of(n)
   // ----------------------------------------------------------------------
   localparam int NSRC = 24;

   function automatic via_pkg::via_vec_t vec_of(input int n);
      via_pkg::via_vec_t v;
      v = `VIA_VEC_NONE;
      case (n)
         0: v = `VIA_VEC_OEP1;
         1: v = `VIA_VEC_OEP2;
         2: v = `VIA_VEC_OEP3;
         3: v = `VIA_VEC_IEP1;
         4: v = `VIA_VEC_IEP2;
         5: v = `VIA_VEC_IEP3;
         6: v = `VIA_VEC_SETUP_OVWR;
         7: v = `VIA_VEC_SETUP;
         8: v = `VIA_VEC_RESUME;
         9: v = `VIA_VEC_SUSPEND;
         10: v = `VIA_VEC_BUSRST;
         11: v = `VIA_VEC_WAKEUP;
         12: v = `VIA_VEC_TW_TX_EMPTY;
         13: v = `VIA_VEC_TW_RX_FULL;
         14: v = `VIA_VEC_IEP0;
         15: v = `VIA_VEC_OEP0;
         16: v = `VIA_VEC_U_STAT;
         17: v = `VIA_VEC_U_MODEM;
         18: v = `VIA_VEC_U_RX_FULL;
         19: v = `VIA_VEC_U_TX_EMPTY;
         20: v = `VIA_VEC_DMA_ONE;
         21: v = `VIA_VEC_DMA_THREE;
         default: v = `VIA_VEC_NONE;
      endcase
      return v;
   endfunction

   // group field of a source; a call result cannot be part-selected directly
   function automatic logic [3:0] grp_of(input int n);
      via_pkg::via_vec_t v;
      v = vec_of(n);
      return v[7:4];
   endfunction

   logic [7:0] standard_irq_enable;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] raw;
   logic [NSRC-1:0] raw_q;
   logic [NSRC-1:0] arrive;
   logic [7:0] age [NSRC];
   logic [NSRC-1:0] next_pend;
   logic [4:0] cur_idx;
   logic cur_valid;
   via_pkg::via_vec_t pending_vector_id;
   via_pkg::via_trig_e trig_mode;
   logic vec_wr;
   logic en_wr;

   assign vec_wr = clk_en && reg_wr && (reg_addr == `VIA_PENDING_VECTOR_ADDR);
   assign en_wr = clk_en && reg_wr && (reg_addr == `VIA_STD_IRQ_ENABLE_ADDR);

   // ----------------------------------------------------------------------
   // source gating
   // ----------------------------------------------------------------------
   always_comb
   begin
      raw = periph_irq;
      raw[16] = periph_irq[16] & uart_irq_mask[1];
      raw[17] = periph_irq[17] & uart_irq_mask[0];
      raw[18] = periph_irq[18] & uart_irq_mask[2];
      raw[19] = periph_irq[19] & uart_irq_mask[2];
      raw[NSRC-1:22] = '0;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         raw_q <= '0;
      else if (clk_en)
         raw_q <= raw;
   end

   // requests are rising edges so a retired source needs a fresh request
   assign arrive = raw & ~raw_q;

   // ----------------------------------------------------------------------
   // pending flags; arrival wins over retire
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_pend = pend;
      if (vec_wr && cur_valid)
         next_pend[cur_idx] = 1'b0;
      next_pend = next_pend | arrive;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         pend <= '0;
      else if (clk_en)
         pend <= next_pend;
   end

   // arrival stamp: lower stamp means earlier within a group
   logic [7:0] stamp;
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         stamp <= 8'h00;
      else if (clk_en && (|arrive))
         stamp <= stamp + 8'h01;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < NSRC; i++)
            age[i] <= 8'h00;
      end
      else if (clk_en)
      begin
         for (int i = 0; i < NSRC; i++)
            if (arrive[i] && !pend[i])
               age[i] <= stamp;
      end
   end

   // ----------------------------------------------------------------------
   // priority encoder
   // ----------------------------------------------------------------------
   // stamp wrap can reorder very old entries; 256 arrivals is far beyond
   // what firmware leaves unserviced within one group
   always_comb
   begin
      cur_idx = 5'h00;
      cur_valid = 1'b0;
      for (int i = 0; i < NSRC; i++)
      begin
         if (pend[i])
         begin
            if (!cur_valid)
            begin
               cur_idx = 5'(i);
               cur_valid = 1'b1;
            end
            else if (grp_of(i) > grp_of(int'(cur_idx)))
               cur_idx = 5'(i);
            else if ((grp_of(i) == grp_of(int'(cur_idx)))
                     && (8'(age[i] - stamp) < 8'(age[cur_idx] - stamp)))
               cur_idx = 5'(i);
         end
      end
   end

   // group in 7:4, index in 3:1, bit 0 zero; 0 when idle
   assign pending_vector_id = cur_valid ? (vec_of(int'(cur_idx)) & 8'hFE)
                                        : `VIA_VEC_NONE;

   // ----------------------------------------------------------------------
   // enable register and trigger mode
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         standard_irq_enable <= `VIA_STD_IRQ_ENABLE_RESET;
      else if (en_wr)
         standard_irq_enable <= reg_wdata & `VIA_STD_IRQ_ENABLE_WMASK;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         trig_mode <= via_pkg::VIA_EDGE;
      else if (clk_en)
      begin
         case (trig_mode)
            via_pkg::VIA_EDGE: if (ext0_level_mode) trig_mode <= via_pkg::VIA_LEVEL;
            via_pkg::VIA_LEVEL: if (!ext0_level_mode) trig_mode <= via_pkg::VIA_EDGE;
            default: trig_mode <= via_pkg::VIA_EDGE;
         endcase
      end
   end
   assign ext0_edge_trig = (trig_mode != via_pkg::VIA_LEVEL);

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         combined_peripheral_irq_line <= 1'b1;
      else if (clk_en)
         combined_peripheral_irq_line <= ~(|next_pend);
   end

   logic [4:0] next_req;
   logic [4:0] src_vec;
   assign src_vec = {serial_port_irq, timer_one_irq, external_one_irq, timer_zero_irq,
                     ~combined_peripheral_irq_line};
   assign next_req = standard_irq_enable[`VIA_EN_GLOBAL] ?
                     (src_vec & standard_irq_enable[4:0]) : 5'h00;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         core_irq_req <= 5'h00;
      else if (clk_en)
         core_irq_req <= next_req;
   end

   // one core start address, highest-priority request chosen
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         core_irq_addr <= `VIA_ADDR_RESET;
      else if (clk_en)
      begin
         if (next_req[0]) core_irq_addr <= `VIA_ADDR_EXT0;
         else if (next_req[1]) core_irq_addr <= `VIA_ADDR_TMR0;
         else if (next_req[2]) core_irq_addr <= `VIA_ADDR_EXT1;
         else if (next_req[3]) core_irq_addr <= `VIA_ADDR_TMR1;
         else if (next_req[4]) core_irq_addr <= `VIA_ADDR_SER;
         else core_irq_addr <= `VIA_ADDR_RESET;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (clk_en)
      begin
         if (reg_addr == `VIA_PENDING_VECTOR_ADDR)
            reg_rdata <= pending_vector_id;
         else if (reg_addr == `VIA_STD_IRQ_ENABLE_ADDR)
            reg_rdata <= standard_irq_enable;
         else
            reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_bit0;
      @(posedge sys_clk) disable iff (reset) pending_vector_id[0] == 1'b0;
   endproperty
   a_bit0: assert property (p_bit0) else $error("vector bit 0 set");

   property p_idle;
      @(posedge sys_clk) disable iff (reset) (pend == '0) |-> pending_vector_id == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("idle vector not zero");

   property p_line;
      @(posedge sys_clk) disable iff (reset)
         clk_en |=> (combined_peripheral_irq_line == (pend == '0));
   endproperty
   a_line: assert property (p_line) else $error("line disagrees with pending");

   property p_retire;
      @(posedge sys_clk) disable iff (reset)
         (vec_wr && cur_valid && !arrive[cur_idx]) |=> !pend[$past(cur_idx)];
   endproperty
   a_retire: assert property (p_retire) else $error("vector not retired");

   property p_setwins;
      @(posedge sys_clk) disable iff (reset)
         (clk_en && arrive[0]) |=> pend[0];
   endproperty
   a_setwins: assert property (p_setwins) else $error("arrival lost");

   property p_global;
      @(posedge sys_clk) disable iff (reset)
         (clk_en && !standard_irq_enable[7]) |=> core_irq_req == 5'h00;
   endproperty
   a_global: assert property (p_global) else $error("masked request");

   property p_dma_channel_one;
      @(posedge sys_clk) disable iff (reset)
         (pend[20] && !pend[21]) |-> pending_vector_id == 8'h80;
   endproperty
   a_dma_channel_one: assert property (p_dma_channel_one) else $error("dma one not top");

   property p_edge;
      @(posedge sys_clk) disable iff (reset)
         (clk_en && !ext0_level_mode) |=> ext0_edge_trig;
   endproperty
   a_edge: assert property (p_edge) else $error("not edge mode");

   property p_uart;
      @(posedge sys_clk) disable iff (reset)
         (clk_en && !uart_irq_mask[2] && !pend[18]) |=> !pend[18];
   endproperty
   a_uart: assert property (p_uart) else $error("masked uart rx");

endmodule
